// [verilog/asc_pkg.sv]
/*
 package for the async sram host controller: geometry, timing counts,
 request and pin bundle types. assumes a 250 mhz system clock.
*/
package asc_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CLK_PERIOD_PS = 4000;
    // cycle and access time of the memory
    localparam int T_CYCLE_NS = 45;
    localparam int CYC_ACCESS = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // write pulse width, least
    localparam int T_WP_NS = 35;
    localparam int CYC_WP = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // output disable to high-z, longest; bus turnaround guard
    localparam int T_HZ_NS = 18;
    localparam int CYC_HZ = (T_HZ_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    // retention_recovery_time
    localparam int T_RECOVERY_MS = 5;
    // divide first: picoseconds per 5 ms overflow a 32-bit int
    localparam int CYC_RECOVERY = T_RECOVERY_MS
        * (1000 * 1000 * 1000 / CLK_PERIOD_PS);
    localparam int CNT_W = 24;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] data;
        logic [1:0] lane_en;
    } asc_req_t;

    typedef struct packed {
        logic chip_select_low_active;
        logic chip_select_high_active;
        logic write_enable_n;
        logic output_enable_n;
        logic lower_lane_select_n;
        logic upper_lane_select_n;
        logic [ADDR_W-1:0] word_address;
    } asc_pins_t;
endpackage : asc_pkg

// [verilog/asc_ctrl.sv]
/*
 host controller for a 262144 x 16 asynchronous static ram.
 assumes the memory pins are wired directly; the bench resolves the shared
 data bus from o_data_oe and the memory's own drive. inputs synchronous.
*/
// Contract
// RL1: memory keeps 262144 sixteen-bit words; reads return last written data.
// RL2: one word chosen by the 18-bit word_address per access.
// RL3: lanes are bits 7:0 and 15:8, each gated by its select.
// RL4: standby when a chip select is inactive or both lane selects high.
// RL5: read drives only lanes whose select is low.
// RL6: write takes data on selected lanes, output enable ignored.
// RL7: output enable high with write enable high: lanes idle, no write.
// RL8: write starts when chip selects, write enable and a lane all active.
// RL9: data captured only during overlap of all write controls.
// RL10: write ends when any qualifying control goes inactive.
// RL11: host drives data only after write enable disables memory outputs.
// RL12: data lanes shared and bidirectional, released when no read.
// RL13: read and write cycles last at least 45 ns.
// RL14: deasserted high chip select gates off all other input buffers.
// RL15: retention by high chip select low lets other inputs float.
// RL16: retention by low chip select keeps high chip select firm.
// RL17: wait at least 5 ms after retention before any access.
// RL18: address held stable from write start to write end.
// RL19: standby and retention cause no write; contents preserved.
`timescale 1ns/1ps
module asc_ctrl #(
    parameter int RECOVERY_CYCLES = asc_pkg::CYC_RECOVERY
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // request port
    input wire logic i_req_valid,
    input wire asc_pkg::asc_req_t i_req,
    output logic o_req_ready,
    output logic o_rd_valid,
    output logic [asc_pkg::DATA_W-1:0] o_rd_data,
    // retention control
    input wire logic i_retain,
    output logic o_retaining,
    // memory pins
    output asc_pkg::asc_pins_t o_pins,
    output logic [asc_pkg::DATA_W-1:0] o_data_out,
    output logic [1:0] o_data_oe,
    input wire logic [asc_pkg::DATA_W-1:0] i_data_in
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_READ, ST_WSETUP, ST_WPULSE, ST_WEND, ST_RETAIN,
        ST_RECOVER
    } asc_state_t;

    // one cycle beyond the access time: the pins lag the state by a register
    localparam logic [asc_pkg::CNT_W-1:0] ACC_LAST =
        asc_pkg::CNT_W'(asc_pkg::CYC_ACCESS);
    localparam logic [asc_pkg::CNT_W-1:0] WP_LAST =
        asc_pkg::CNT_W'(asc_pkg::CYC_WP - 1);
    localparam logic [asc_pkg::CNT_W-1:0] HZ_LAST =
        asc_pkg::CNT_W'(asc_pkg::CYC_HZ - 1);
    localparam logic [asc_pkg::CNT_W-1:0] REC_LAST =
        asc_pkg::CNT_W'(RECOVERY_CYCLES - 1);

    asc_state_t state;
    logic [asc_pkg::CNT_W-1:0] cnt;
    logic [asc_pkg::CNT_W-1:0] span;
    logic cnt_done;
    asc_pkg::asc_req_t cur;

    assign cnt_done = (cnt == 0);
    // ready only in idle so retention recovery blocks new accesses
    assign o_req_ready = (state == ST_IDLE) && !i_retain; // [RL17]

    // sequencer
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            span <= '0;
        end
        else
        begin
            if (!cnt_done)
                cnt <= cnt - 1'b1;
            if (state != ST_IDLE && state != ST_RETAIN)
                span <= span + 1'b1;
            case (state)
                ST_IDLE:
                    if (i_retain)
                        state <= ST_RETAIN;
                    else if (i_req_valid && i_req.lane_en != 2'b00)
                    begin
                        span <= '0;
                        if (i_req.write)
                        begin
                            // memory outputs need time to release first
                            state <= ST_WSETUP; // [RL11]
                            cnt <= HZ_LAST;
                        end
                        else
                        begin
                            state <= ST_READ;
                            cnt <= ACC_LAST; // [RL13]
                        end
                    end
                ST_READ:
                    if (cnt_done)
                        state <= ST_IDLE;
                ST_WSETUP:
                    if (cnt_done)
                    begin
                        state <= ST_WPULSE;
                        cnt <= WP_LAST;
                    end
                ST_WPULSE:
                    if (cnt_done)
                        state <= ST_WEND;
                ST_WEND:
                    state <= ST_IDLE;
                ST_RETAIN:
                    if (!i_retain)
                    begin
                        state <= ST_RECOVER;
                        cnt <= REC_LAST; // [RL17]
                    end
                ST_RECOVER:
                    if (i_retain)
                        state <= ST_RETAIN;
                    else if (cnt_done)
                        state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // request capture; address and lanes frozen for the whole access
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            cur <= '0;
        else if (state == ST_IDLE && i_req_valid && !i_retain)
            cur <= i_req; // [RL18]
    end

    // pin drive, registered
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_pins <= '0;
            o_pins.chip_select_low_active <= 1'b1;
            o_pins.write_enable_n <= 1'b1;
            o_pins.output_enable_n <= 1'b1;
            o_pins.lower_lane_select_n <= 1'b1;
            o_pins.upper_lane_select_n <= 1'b1;
            o_data_out <= '0;
            o_data_oe <= 2'b00;
        end
        else
        begin
            o_pins.word_address <= cur.word_address; // [RL2]
            o_data_out <= cur.data;
            // low chip select alone deselects; high one stays firm
            o_pins.chip_select_high_active <= 1'b1; // [RL16] [RL15]
            o_pins.chip_select_low_active <= !(state == ST_READ
                || state == ST_WSETUP || state == ST_WPULSE); // [RL4]
            o_pins.output_enable_n <= (state != ST_READ); // [RL5] [RL7]
            o_pins.write_enable_n <= !(state == ST_WSETUP
                || state == ST_WPULSE); // [RL8]
            if (state == ST_READ || state == ST_WSETUP
                || state == ST_WPULSE)
            begin
                o_pins.lower_lane_select_n <= !cur.lane_en[0]; // [RL3]
                o_pins.upper_lane_select_n <= !cur.lane_en[1]; // [RL3]
            end
            else
            begin
                // write ends by the lane selects, write enable and low chip select together
                o_pins.lower_lane_select_n <= 1'b1; // [RL10]
                o_pins.upper_lane_select_n <= 1'b1; // [RL10]
            end
            // data held through pulse and one cycle after its end
            if (state == ST_WPULSE || state == ST_WEND)
                o_data_oe <= cur.lane_en; // [RL9] [RL6] [RL12]
            else
                o_data_oe <= 2'b00; // [RL12]
        end
    end

    // read capture at the end of the access time
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_rd_valid <= 1'b0;
            o_rd_data <= '0;
        end
        else
        begin
            o_rd_valid <= (state == ST_READ) && cnt_done; // [RL1]
            if (state == ST_READ && cnt_done)
            begin
                o_rd_data[asc_pkg::LANE_W-1:0] <= cur.lane_en[0]
                    ? i_data_in[asc_pkg::LANE_W-1:0] : '0;
                o_rd_data[asc_pkg::DATA_W-1:asc_pkg::LANE_W] <=
                    cur.lane_en[1]
                    ? i_data_in[asc_pkg::DATA_W-1:asc_pkg::LANE_W] : '0;
            end
        end
    end

    assign o_retaining = (state == ST_RETAIN);

    // assertions
    AST_NO_CONTENTION: assert property (@(posedge i_clk) // [RL11]
        disable iff (!i_arst_n)
        (o_data_oe != 2'b00) |-> o_pins.output_enable_n)
        else $error("host drives data while memory outputs enabled");

    AST_WRITE_DRIVES: assert property (@(posedge i_clk) // [RL9]
        disable iff (!i_arst_n)
        $rose(o_pins.write_enable_n) |-> (o_data_oe != 2'b00
            && $past(o_data_oe, 7) != 2'b00))
        else $error("write data not held through the overlap");

    AST_CS2_FIRM: assert property (@(posedge i_clk) // [RL16]
        disable iff (!i_arst_n)
        $past(i_arst_n) |-> o_pins.chip_select_high_active)
        else $error("high chip select not held");

    AST_ADDR_STABLE: assert property (@(posedge i_clk) // [RL18]
        disable iff (!i_arst_n)
        (!o_pins.write_enable_n && $past(!o_pins.write_enable_n))
        |-> $stable(o_pins.word_address))
        else $error("address moved during write");

    sequence s_read_go;
        state == ST_IDLE && i_req_valid && !i_retain && i_req.lane_en != 0
        && !i_req.write;
    endsequence
    AST_READ_LEN: assert property (@(posedge i_clk) // [RL13]
        disable iff (!i_arst_n)
        s_read_go |=> !o_rd_valid [*7] ##1 !o_rd_valid [*6] ##1 o_rd_valid)
        else $error("read shorter than access time");

    AST_WP_LEN: assert property (@(posedge i_clk) // [RL8]
        disable iff (!i_arst_n)
        $fell(o_pins.write_enable_n) |-> !o_pins.write_enable_n [*8])
        else $error("write pulse too short");

    AST_RECOVER: assert property (@(posedge i_clk) // [RL17]
        disable iff (!i_arst_n)
        (state == ST_RETAIN || state == ST_RECOVER) |-> !o_req_ready)
        else $error("access offered during recovery");

    AST_STANDBY_IDLE: assert property (@(posedge i_clk) // [RL4]
        disable iff (!i_arst_n)
        o_retaining |=> (o_pins.chip_select_low_active
            && o_pins.write_enable_n && o_data_oe == 2'b00))
        else $error("pins active during retention");

    AST_SPAN: assert property (@(posedge i_clk) // [RL13]
        disable iff (!i_arst_n)
        (state == ST_WEND) |-> (span >= asc_pkg::CNT_W'(asc_pkg::CYC_ACCESS
            - 1)))
        else $error("write cycle shorter than cycle time");
endmodule : asc_ctrl

// [testbench/asc_sram_model.sv]
/*
 behavioural model of the 262144 x 16 asynchronous static ram.
 assumes the bench resolves the shared data bus and feeds it back on i_bus.
*/
`timescale 1ns/1ps
module asc_sram_model #(
    parameter int ACC_NS = 45
) (
    // memory pins
    input wire asc_pkg::asc_pins_t i_pins,
    input wire logic [15:0] i_bus,
    input wire logic [1:0] i_host_oe,
    // memory drive
    output logic [15:0] o_drive,
    output logic [1:0] o_drive_en,
    output logic [7:0] o_faults
);
    logic [15:0] mem [logic [17:0]];
    logic rd;
    logic rd_ok;
    logic was_w = 1'b0;
    logic [17:0] wr_addr;
    logic [1:0] wr_lane;
    logic [15:0] wr_data;
    logic [15:0] word;
    initial o_faults = 8'h00;
    // high select low gates every other input off
    assign rd = i_pins.chip_select_high_active === 1'b1
        && i_pins.chip_select_low_active === 1'b0
        && i_pins.write_enable_n === 1'b1
        && i_pins.output_enable_n === 1'b0;
    // slow part: old data is not shown until access time passes
    assign #(ACC_NS) rd_ok = rd;
    always @(i_pins or rd or rd_ok)
    begin
        word = mem.exists(i_pins.word_address) ?
            mem[i_pins.word_address] : 16'h0000;
        o_drive_en = rd ? ~{i_pins.upper_lane_select_n,
            i_pins.lower_lane_select_n} : 2'h0;
        o_drive = (rd && rd_ok) ? word : ~word;
    end
    always @(i_host_oe or o_drive_en)
        if (|(i_host_oe & o_drive_en))
            o_faults = o_faults + 8'h01;
    // one process for the write so pins and lanes are seen together
    always @(i_pins or i_bus)
    begin
        logic w;
        logic [1:0] ln;
        logic [15:0] old;
        ln = ~{i_pins.upper_lane_select_n, i_pins.lower_lane_select_n};
        w = i_pins.chip_select_high_active === 1'b1
            && i_pins.chip_select_low_active === 1'b0
            && i_pins.write_enable_n === 1'b0 && ln != 2'h0;
        if (w)
        begin
            if (was_w && i_pins.word_address !== wr_addr)
                o_faults = o_faults + 8'h01;
            wr_addr = i_pins.word_address;
            wr_lane = ln;
            wr_data = i_bus;
        end
        else if (was_w)
        begin
            old = mem.exists(wr_addr) ? mem[wr_addr] : 16'h0000;
            mem[wr_addr] = {wr_lane[1] ? wr_data[15:8] : old[15:8],
                wr_lane[0] ? wr_data[7:0] : old[7:0]};
        end
        was_w = w;
    end
endmodule : asc_sram_model

// [testbench/async_sram_256k_x16_tb_top.sv]
/*
 self-checking bench for the sram host controller with a memory model.
 assumes recovery shortened to 20 cycles; inputs change on falling edges.
*/
`timescale 1ns/1ps
module async_sram_256k_x16_tb_top;
    localparam int RECOV = 20;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_req_valid = 1'b0;
    asc_pkg::asc_req_t i_req = '0;
    logic i_retain = 1'b0;
    logic o_req_ready;
    logic o_rd_valid;
    logic o_retaining;
    logic [15:0] o_rd_data;
    logic [15:0] o_data_out;
    logic [15:0] i_data_in;
    logic [15:0] drive;
    logic [15:0] noise = 16'h5a3c;
    logic [1:0] o_data_oe;
    logic [1:0] drive_en;
    logic [7:0] faults;
    asc_pkg::asc_pins_t o_pins;
    int num_errors = 0;
    int check_count = 0;
    always #2 i_clk = ~i_clk;
    // a released bus shows a changing pattern, never its last value
    always @(posedge i_clk) noise <= ~noise;
    assign i_data_in[7:0] = o_data_oe[0] ? o_data_out[7:0] :
        drive_en[0] ? drive[7:0] : noise[7:0];
    assign i_data_in[15:8] = o_data_oe[1] ? o_data_out[15:8] :
        drive_en[1] ? drive[15:8] : noise[15:8];
    asc_ctrl #(.RECOVERY_CYCLES(RECOV)) i_asc_ctrl (.i_clk(i_clk),
        .i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
        .o_rd_data(o_rd_data), .i_retain(i_retain),
        .o_retaining(o_retaining), .o_pins(o_pins),
        .o_data_out(o_data_out), .o_data_oe(o_data_oe),
        .i_data_in(i_data_in));
    asc_sram_model i_asc_sram_model (.i_pins(o_pins), .i_bus(i_data_in),
        .i_host_oe(o_data_oe), .o_drive(drive), .o_drive_en(drive_en),
        .o_faults(faults));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    task automatic issue(input logic wr, input logic [17:0] a,
        input logic [15:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        @(negedge i_clk);
        while (o_req_ready !== 1'b1 && n < 200)
        begin
            @(negedge i_clk);
            n++;
        end
        i_req = '{write: wr, word_address: a, data: d, lane_en: ln};
        i_req_valid = 1'b1;
        @(negedge i_clk);
        i_req_valid = 1'b0;
    endtask : issue
    // counts edges after the take until ready or read data returns
    task automatic wait_for(input logic rd, output int k);
        k = 0;
        do
        begin
            @(posedge i_clk);
            #1;
            k++;
        end while ((rd ? o_rd_valid : o_req_ready) !== 1'b1 && k < 100);
    endtask : wait_for
    task automatic t_write(input logic [17:0] a, input logic [15:0] d,
        input logic [1:0] ln);
        int k;
        issue(1'b1, a, d, ln);
        wait_for(1'b0, k);
        if (ln != 2'h0)
            chk(k, 15);
        else
            chk(k, 1);
    endtask : t_write
    task automatic t_read(input logic [17:0] a, input logic [1:0] ln,
        input logic [15:0] exp);
        int k;
        issue(1'b0, a, 16'h0000, ln);
        wait_for(1'b1, k);
        chk(k, 13);
        chk(o_rd_data, exp);
        @(posedge i_clk);
        #1;
        chk(o_rd_valid, 1'b0);
    endtask : t_read
    task automatic sc_idle();
        chk(o_pins.chip_select_high_active, 1'b1);
        chk(o_pins.chip_select_low_active, 1'b1);
        chk(o_data_oe, 2'h0);
    endtask : sc_idle
    task automatic sc_edges();
        t_write(18'h00000, 16'h1234, 2'h3);
        t_write(18'h3ffff, 16'hcafe, 2'h3);
        t_read(18'h00000, 2'h3, 16'h1234);
        t_read(18'h3ffff, 2'h3, 16'hcafe);
    endtask : sc_edges
    task automatic sc_lanes();
        t_write(18'h00005, 16'haaaa, 2'h3);
        t_write(18'h00005, 16'h0011, 2'h1);
        t_write(18'h00005, 16'h2200, 2'h2);
        t_write(18'h00005, 16'hffff, 2'h0);
        t_read(18'h00005, 2'h3, 16'h2211);
        t_read(18'h00005, 2'h1, 16'h0011);
        t_read(18'h00005, 2'h2, 16'h2200);
    endtask : sc_lanes
    task automatic sc_retain();
        int k;
        @(negedge i_clk);
        i_retain = 1'b1;
        repeat (10) @(negedge i_clk);
        chk(o_retaining, 1'b1);
        chk(o_pins.chip_select_low_active, 1'b1);
        chk(o_pins.chip_select_high_active, 1'b1);
        chk(o_req_ready, 1'b0);
        i_retain = 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_retaining, 1'b0);
        chk(o_req_ready, 1'b0);
        i_retain = 1'b1;
        repeat (2) @(negedge i_clk);
        chk(o_retaining, 1'b1);
        i_retain = 1'b0;
        wait_for(1'b0, k);
        chk(k, RECOV + 1);
        t_read(18'h00005, 2'h3, 16'h2211);
    endtask : sc_retain
    initial
    begin
        repeat (2) @(negedge i_clk);
        i_arst_n = 1'b1;
        @(negedge i_clk);
        sc_idle();
        sc_edges();
        sc_lanes();
        sc_retain();
        chk(faults, 8'h00);
        tally_and_finish();
    end
    // whole run is about two hundred cycles; this allows over twenty times that
    initial
    begin
        #20000;
        num_errors++;
        tally_and_finish();
    end
endmodule : async_sram_256k_x16_tb_top
